//--- rxc_receiver_config.sv
`include "rxc_cfg.svh"
`default_nettype none
module rxc_receiver_config #(
  parameter int ADDR_W = 8,
  parameter int SQ_DELAY_CYC = `RXC_SQ_DELAY_CYC
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [ADDR_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic tx_end, // end of transmission pulse
  input wire logic [7:0] mrt_value, // mask receive timer
  input wire logic [7:0] squelch_time, // programmed squelch time
  input wire logic rx_active, // receive period
  input wire logic subcarrier_pulse, // one pulse per subcarrier pulse
  output logic demod_iq, // I/Q demodulation
  output logic am_mixer_select, // AM mixer instead of peak
  output logic squelch_active, // squelch running
  output logic squelch_ratio_high, // ratio 6/3
  output logic agc_active, // gain control running
  output logic agc_alg_reset, // reset variant
  output logic gain_control_ratio, // 6x trigger
  output logic [2:0] am_first_stage_gain, // AM first code
  output logic [2:0] pm_first_stage_gain, // PM first code
  output logic [2:0] am_first_cut, // AM 2.5 dB steps
  output logic [2:0] pm_first_cut, // PM 2.5 dB steps
  output logic am_first_boost, // AM boost
  output logic pm_first_boost, // PM boost
  output logic low_freq_input_select, // LF input
  output logic low_freq_split_mode, // split inputs
  output logic [3:0] am_later_stage_gain, // AM loaded code
  output logic [3:0] pm_later_stage_gain, // PM loaded code
  output logic [2:0] am_window_steps, // AM window 3 dB steps
  output logic [2:0] pm_window_steps, // PM window 3 dB steps
  output logic [2:0] am_stage_steps, // AM stage 3 dB steps
  output logic [2:0] pm_stage_steps, // PM stage 3 dB steps
  output logic gain_loaded // load pulse seen by gain users
);
  import rxc_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
    $error("rxc_receiver_config: ADDR_W out of range");
  end
  if (SQ_DELAY_CYC < 2 || SQ_DELAY_CYC > 65535) begin : g_bad_delay
    $error("rxc_receiver_config: SQ_DELAY_CYC out of range");
  end

  localparam logic [15:0] SQ_LAST = 16'(SQ_DELAY_CYC - 1);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  rxc_reg_t reg_ctrl;
  rxc_reg_t reg_first;
  rxc_reg_t reg_later;
  logic wr_pend;
  logic [ADDR_W-3:0] wr_idx;
  wire addr_take;
  wire [ADDR_W-3:0] a_idx;
  wire [7:0] a_idx8;
  wire [7:0] w_idx8;
  wire wr_ctrl;
  wire wr_first;
  wire wr_later;
  wire wr_cmd;
  wire load_cmd;
  wire [7:0] status_word;
  logic [7:0] rd_mux;

  assign addr_take = hsel & htrans[1] & hready;
  assign a_idx = haddr[ADDR_W-1:2];
  assign a_idx8 = 8'(a_idx);
  assign w_idx8 = 8'(wr_idx);
  assign wr_ctrl = wr_pend & (w_idx8 == `RXC_IDX_DEMOD_SQ_AGC);
  assign wr_first = wr_pend & (w_idx8 == `RXC_IDX_FIRST_GAIN);
  assign wr_later = wr_pend & (w_idx8 == `RXC_IDX_LATER_GAIN);
  assign wr_cmd = wr_pend & (w_idx8 == `RXC_IDX_COMMAND);
  assign load_cmd = wr_cmd & hwdata[`RXC_BIT_CMD_LOAD_GAIN];

  always_comb begin
    unique case (a_idx8)
      `RXC_IDX_DEMOD_SQ_AGC: rd_mux = reg_ctrl;
      `RXC_IDX_FIRST_GAIN: rd_mux = reg_first;
      `RXC_IDX_LATER_GAIN: rd_mux = reg_later;
      `RXC_IDX_STATUS: rd_mux = status_word;
      default: rd_mux = 8'h00;
    endcase
  end

  // zero wait states; read data captured at the address phase edge,
  // so a read must not overlap the data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_take & hwrite & (hsize == 3'h2);
      wr_idx <= a_idx;
      hrdata <= (addr_take & ~hwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_ctrl <= `RXC_RST_DEMOD_SQ_AGC;
      reg_first <= `RXC_RST_FIRST_GAIN;
      reg_later <= `RXC_RST_LATER_GAIN;
    end else begin
      if (wr_ctrl) reg_ctrl <= hwdata[7:0];
      if (wr_first) reg_first <= hwdata[7:0];
      if (wr_later) reg_later <= hwdata[7:0];
    end
  end

  assign demod_iq = reg_ctrl[`RXC_BIT_DEMOD_IQ];
  assign am_mixer_select = reg_ctrl[`RXC_BIT_AM_MIXER];
  assign squelch_ratio_high = reg_ctrl[`RXC_BIT_SQ_RATIO];
  assign agc_alg_reset = reg_ctrl[`RXC_BIT_AGC_ALG];
  assign gain_control_ratio = reg_ctrl[`RXC_BIT_AGC_RATIO];
  assign am_first_stage_gain = reg_first[`RXC_FLD_AM_FIRST_HI:`RXC_FLD_AM_FIRST_LO];
  assign pm_first_stage_gain = reg_first[`RXC_FLD_PM_FIRST_HI:`RXC_FLD_PM_FIRST_LO];
  assign low_freq_input_select = reg_first[`RXC_BIT_LF_SELECT];
  assign low_freq_split_mode = reg_first[`RXC_BIT_LF_SPLIT];

  // ----------------------------------------------------------------
  // gain load on command
  // ----------------------------------------------------------------
  // later stage gain users keep the old values until software issues the command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      am_later_stage_gain <= 4'h0;
      pm_later_stage_gain <= 4'h0;
      gain_loaded <= 1'b0;
    end else begin
      if (load_cmd) begin
        am_later_stage_gain <= reg_later[7:4];
        pm_later_stage_gain <= reg_later[3:0];
      end
      gain_loaded <= load_cmd;
    end
  end

  // ----------------------------------------------------------------
  // per channel decode
  // ----------------------------------------------------------------
  wire [2:0] dec_first_cut [2];
  wire dec_first_boost [2];
  wire [2:0] dec_window [2];
  wire [2:0] dec_stage [2];
  wire dec_bad [2];
  wire [2:0] ch_first [2];
  wire [3:0] ch_later [2];
  logic [2:0] q_first_cut [2];
  logic q_first_boost [2];
  logic [2:0] q_window [2];
  logic [2:0] q_stage [2];
  logic q_bad [2];

  assign ch_first[0] = am_first_stage_gain;
  assign ch_first[1] = pm_first_stage_gain;
  assign ch_later[0] = am_later_stage_gain;
  assign ch_later[1] = pm_later_stage_gain;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    rxc_gain_decode u_dec (
      .first_code(ch_first[ch]),
      .later_code(ch_later[ch]),
      .first_cut_steps(dec_first_cut[ch]),
      .first_boost(dec_first_boost[ch]),
      .window_steps(dec_window[ch]),
      .stage_steps(dec_stage[ch]),
      .later_bad(dec_bad[ch])
    );
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        q_first_cut[ch] <= 3'h6;
        q_first_boost[ch] <= 1'b0;
        q_window[ch] <= 3'h0;
        q_stage[ch] <= 3'h0;
        q_bad[ch] <= 1'b0;
      end else begin
        q_first_cut[ch] <= dec_first_cut[ch];
        q_first_boost[ch] <= dec_first_boost[ch];
        q_window[ch] <= dec_window[ch];
        q_stage[ch] <= dec_stage[ch];
        q_bad[ch] <= dec_bad[ch];
      end
    end
  end

  assign am_first_cut = q_first_cut[0];
  assign pm_first_cut = q_first_cut[1];
  assign am_first_boost = q_first_boost[0];
  assign pm_first_boost = q_first_boost[1];
  assign am_window_steps = q_window[0];
  assign pm_window_steps = q_window[1];
  assign am_stage_steps = q_stage[0];
  assign pm_stage_steps = q_stage[1];

  // ----------------------------------------------------------------
  // squelch sequencing
  // ----------------------------------------------------------------
  rxc_sq_state_t sq_state;
  rxc_sq_state_t next_sq_state;
  logic [15:0] sq_cnt;
  wire sq_auto;
  wire sq_done;

  assign sq_auto = reg_ctrl[`RXC_BIT_SQ_AUTO];
  assign sq_done = (mrt_value >= squelch_time);

  always_comb begin
    next_sq_state = sq_state;
    unique case (sq_state)
      SQ_IDLE: if (sq_auto && tx_end) next_sq_state = SQ_WAIT;
      SQ_WAIT: begin
        if (!sq_auto) next_sq_state = SQ_IDLE;
        else if (sq_cnt == SQ_LAST) next_sq_state = SQ_ON;
      end
      SQ_ON: if (!sq_auto || sq_done) next_sq_state = SQ_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_state <= SQ_IDLE;
      sq_cnt <= 16'h0000;
      squelch_active <= 1'b0;
    end else begin
      sq_state <= next_sq_state;
      sq_cnt <= (sq_state == SQ_WAIT) ? sq_cnt + 16'h0001 : 16'h0000;
      squelch_active <= (next_sq_state == SQ_ON);
    end
  end

  // ----------------------------------------------------------------
  // gain control window
  // ----------------------------------------------------------------
  logic [3:0] pulse_cnt;
  logic next_agc_active;
  wire agc_en;
  wire agc_full;
  wire early_window;

  assign agc_en = reg_ctrl[`RXC_BIT_AGC_EN];
  assign agc_full = reg_ctrl[`RXC_BIT_AGC_FULL];
  assign early_window = (pulse_cnt < `RXC_AGC_PULSES);

  always_comb begin
    next_agc_active = agc_en & rx_active & (agc_full | early_window);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt <= 4'h0;
      agc_active <= 1'b0;
    end else begin
      if (!rx_active) pulse_cnt <= 4'h0;
      else if (subcarrier_pulse && early_window) pulse_cnt <= pulse_cnt + 4'h1;
      agc_active <= next_agc_active;
    end
  end

  // status: bit0 squelch, bit1 gain control, bit2/3 AM/PM code above Ah
  assign status_word = {4'h0, q_bad[1], q_bad[0], agc_active, squelch_active};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] chk_wait;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) chk_wait <= 16'h0000;
    else if (sq_state == SQ_IDLE) chk_wait <= 16'h0000;
    else if (sq_state == SQ_WAIT) chk_wait <= chk_wait + 16'h0001;
  end

  a_demod_mode_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> demod_iq == $past(hwdata[`RXC_BIT_DEMOD_IQ]))
    else $error("demodulation mode did not follow write");
  a_squelch_start_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(squelch_active) |-> chk_wait == 16'(SQ_DELAY_CYC))
    else $error("squelch started at wrong delay");
  a_squelch_stop_time: assert property (@(posedge hclk) disable iff (!hresetn)
    (squelch_active && sq_done) |=> !squelch_active)
    else $error("squelch did not stop at squelch time");
  a_squelch_ratio_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> squelch_ratio_high == $past(hwdata[`RXC_BIT_SQ_RATIO]))
    else $error("squelch ratio did not follow write");
  a_agc_early_window: assert property (@(posedge hclk) disable iff (!hresetn)
    (!agc_full && !early_window) |=> !agc_active)
    else $error("gain control ran past eight pulses");
  a_agc_alg_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> agc_alg_reset == $past(hwdata[`RXC_BIT_AGC_ALG]))
    else $error("gain control algorithm did not follow write");
  a_agc_ratio_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> gain_control_ratio == $past(hwdata[`RXC_BIT_AGC_RATIO]))
    else $error("gain control ratio did not follow write");
  a_first_gain_boost: assert property (@(posedge hclk) disable iff (!hresetn)
    am_first_boost |-> $past(am_first_stage_gain) == 3'h7 && am_first_cut == 3'h0)
    else $error("first stage boost decoded wrongly");
  a_lf_select_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_first |=> low_freq_input_select == $past(hwdata[`RXC_BIT_LF_SELECT]))
    else $error("input select did not follow write");
  a_lf_split_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_first |=> low_freq_split_mode == $past(hwdata[`RXC_BIT_LF_SPLIT]))
    else $error("split mode did not follow write");
  a_later_gain_range: assert property (@(posedge hclk) disable iff (!hresetn)
    (am_window_steps <= 3'h4) && (am_stage_steps == 3'h0 || am_window_steps == 3'h4))
    else $error("later stage decode out of order");
  a_later_gain_load: assert property (@(posedge hclk) disable iff (!hresetn)
    ($changed(am_later_stage_gain) || $changed(pm_later_stage_gain)) |-> gain_loaded)
    else $error("later stage gain changed without command");
endmodule
`default_nettype wire

//--- rxc_cfg.svh
`ifndef RXC_CFG_SVH
`define RXC_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RXC_IDX_DEMOD_SQ_AGC 8'h0C
`define RXC_IDX_FIRST_GAIN 8'h0D
`define RXC_IDX_LATER_GAIN 8'h0E
`define RXC_IDX_COMMAND 8'h10
`define RXC_IDX_STATUS 8'h11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RXC_RST_DEMOD_SQ_AGC 8'h2C
`define RXC_RST_FIRST_GAIN 8'hD8
`define RXC_RST_LATER_GAIN 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RXC_BIT_DEMOD_IQ 7
`define RXC_BIT_AM_MIXER 6
`define RXC_BIT_SQ_AUTO 5
`define RXC_BIT_SQ_RATIO 4
`define RXC_BIT_AGC_EN 3
`define RXC_BIT_AGC_FULL 2
`define RXC_BIT_AGC_ALG 1
`define RXC_BIT_AGC_RATIO 0
`define RXC_FLD_AM_FIRST_HI 7
`define RXC_FLD_AM_FIRST_LO 5
`define RXC_FLD_PM_FIRST_HI 4
`define RXC_FLD_PM_FIRST_LO 2
`define RXC_BIT_LF_SELECT 1
`define RXC_BIT_LF_SPLIT 0
`define RXC_BIT_CMD_LOAD_GAIN 0

// ----------------------------------------------------------------
// gain code limits and timing
// ----------------------------------------------------------------
`define RXC_LATER_MAX 4'hA
`define RXC_LATER_WIN_MAX 4'h4
`define RXC_FIRST_BOOST 3'h7
`define RXC_AGC_PULSES 4'h8
`define RXC_CLK_PERIOD_PS 10000
`define RXC_SQ_DELAY_PS 18880000
`define RXC_SQ_DELAY_CYC ((`RXC_SQ_DELAY_PS + `RXC_CLK_PERIOD_PS - 1) / `RXC_CLK_PERIOD_PS)

`endif

//--- rxc_pkg.sv
`default_nettype none
package rxc_pkg;
  typedef logic [7:0] rxc_reg_t;
  typedef logic [3:0] rxc_later_code_t;
  typedef logic [2:0] rxc_first_code_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_ON} rxc_sq_state_t;
endpackage
`default_nettype wire

//--- rxc_gain_decode.sv
`include "rxc_cfg.svh"
`default_nettype none
module rxc_gain_decode
  import rxc_pkg::*;
(
  input wire rxc_pkg::rxc_first_code_t first_code, // first stage code
  input wire rxc_pkg::rxc_later_code_t later_code, // loaded later stage code
  output logic [2:0] first_cut_steps, // 2.5 dB cut steps
  output logic first_boost, // 5.5 dB boost
  output logic [2:0] window_steps, // digitizer window 3 dB steps
  output logic [2:0] stage_steps, // second/third stage 3 dB steps
  output logic later_bad // code above Ah
);
  wire first_is_boost;
  wire later_over;
  wire [3:0] later_clamped;
  wire later_in_stage;
  wire [3:0] stage_raw;

  // ----------------------------------------------------------------
  // first stage: 0 full, 1..6 cut, 7 boost
  // ----------------------------------------------------------------
  assign first_is_boost = (first_code == `RXC_FIRST_BOOST);
  assign first_boost = first_is_boost;
  assign first_cut_steps = first_is_boost ? 3'h0 : first_code;

  // ----------------------------------------------------------------
  // later stage: window first, then stage gain; codes above Ah clamp
  // ----------------------------------------------------------------
  assign later_over = (later_code > `RXC_LATER_MAX);
  assign later_bad = later_over;
  assign later_clamped = later_over ? `RXC_LATER_MAX : later_code;
  assign later_in_stage = (later_clamped > `RXC_LATER_WIN_MAX);
  assign stage_raw = later_clamped - `RXC_LATER_WIN_MAX;
  assign window_steps = later_in_stage ? 3'h4 : later_clamped[2:0];
  assign stage_steps = later_in_stage ? stage_raw[2:0] : 3'h0;
endmodule
`default_nettype wire

//--- rxc_receiver_config_tb.sv
`default_nettype none
module rxc_receiver_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rxc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  // short squelch delay keeps the run small
  localparam int SQ_CYC = 8;
  typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] rexp;} rxc_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, tx_end, rx_active, subcarrier_pulse;
  logic [7:0] haddr, mrt_value, squelch_time, r0c, r0d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic demod_iq, am_mixer_select, squelch_active, squelch_ratio_high, agc_active;
  logic agc_alg_reset, gain_control_ratio, am_first_boost, pm_first_boost, gain_loaded;
  logic low_freq_input_select, low_freq_split_mode;
  logic [2:0] am_first_stage_gain, pm_first_stage_gain, am_first_cut, pm_first_cut;
  logic [2:0] am_window_steps, pm_window_steps, am_stage_steps, pm_stage_steps;
  logic [3:0] am_later_stage_gain, pm_later_stage_gain, am, pm, pa, pp;
  int failures, comparisons, n;
  rxc_row_t rows [11] = '{
    '{8'h30, 8'h40, 8'h40}, '{8'h30, 8'hC0, 8'hC0}, '{8'h30, 8'h13, 8'h13},
    '{8'h30, 8'h2C, 8'h2C}, '{8'h34, 8'h00, 8'h00}, '{8'h34, 8'h24, 8'h24},
    '{8'h34, 8'hFB, 8'hFB}, '{8'h34, 8'h1D, 8'h1D}, '{8'h38, 8'hFF, 8'hFF},
    '{8'h38, 8'h00, 8'h00}, '{8'h60, 8'h55, 8'h00}};

  rxc_receiver_config #(.SQ_DELAY_CYC(SQ_CYC)) dut (.hreadyout(hready), .*);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t %s read %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_out(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t %s ports %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rdy;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  // address phase held until ready, then data phase until ready again
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask

  task automatic pulse;
    @(posedge hclk);
    subcarrier_pulse <= 1'b1;
    @(posedge hclk);
    subcarrier_pulse <= 1'b0;
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic check_defaults(input string what);
    xfer(1'b0, 8'h30, 32'h0, 3'h2);
    chk_rd(rd, 32'h2C, what);
    xfer(1'b0, 8'h34, 32'h0, 3'h2);
    chk_rd(rd, 32'hD8, what);
    xfer(1'b0, 8'h38, 32'h0, 3'h2);
    chk_rd(rd, 32'h00, what);
    chk_out({5'h0, hready, hresp, squelch_active, agc_active, gain_loaded, am_first_cut,
             pm_first_cut, am_later_stage_gain, pm_later_stage_gain},
            {5'h0, 2'b10, 3'h0, 3'h6, 3'h6, 8'h00}, what);
    $display("done: %s", what);
  endtask

  function automatic logic [3:0] fcut(input logic [2:0] c);
    return (c == 3'h7) ? 4'h1 : {c, 1'b0};
  endfunction

  function automatic logic [5:0] dec(input logic [3:0] c);
    return (c > 4'h4) ? {3'h4, 3'(c - 4'h4)} : {c[2:0], 3'h0};
  endfunction

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    $display("[ERR] t=%0t watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, tx_end, rx_active, subcarrier_pulse} = 5'h0;
    {haddr, mrt_value} = 16'h0;
    squelch_time = 8'h10;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {r0c, r0d, pa, pp} = {8'h2C, 8'hD8, 8'h00};
    do_reset();
    check_defaults("reset");
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].addr, {24'h0, rows[i].data}, 3'h2);
      if (rows[i].addr == 8'h30) r0c = rows[i].data;
      if (rows[i].addr == 8'h34) r0d = rows[i].data;
      xfer(1'b0, rows[i].addr, 32'h0, 3'h2);
      chk_rd(rd, {24'h0, rows[i].rexp}, "row");
      #1;
      chk_out({11'h0, demod_iq, am_mixer_select, squelch_ratio_high, agc_alg_reset,
               gain_control_ratio, am_first_stage_gain, pm_first_stage_gain,
               low_freq_input_select, low_freq_split_mode},
              {11'h0, r0c[7], r0c[6], r0c[4], r0c[1], r0c[0], r0d}, "row");
      chk_out({16'h0, am_first_cut, am_first_boost, pm_first_cut, pm_first_boost},
              {16'h0, fcut(r0d[7:5]), fcut(r0d[4:2])}, "row");
    end
    $display("done: table");
    // byte-sized write must leave the register alone
    xfer(1'b1, 8'h34, 32'h0, 3'h0);
    xfer(1'b0, 8'h34, 32'h0, 3'h2);
    chk_rd(rd, {24'h0, r0d}, "hsize");
    $display("done: hsize");
    for (int k = 0; k <= 10; k++) begin
      am = 4'(k);
      pm = 4'(10 - k);
      xfer(1'b1, 8'h38, {24'h0, am, pm}, 3'h2);
      #1;
      chk_out({15'h0, am_later_stage_gain, pm_later_stage_gain, gain_loaded},
              {15'h0, pa, pp, 1'b0}, "preload");
      xfer(1'b1, 8'h40, 32'h1, 3'h2);
      #1;
      chk_out({15'h0, am_later_stage_gain, pm_later_stage_gain, gain_loaded},
              {15'h0, am, pm, 1'b1}, "load");
      @(posedge hclk);
      #1;
      chk_out({11'h0, gain_loaded, am_window_steps, am_stage_steps, pm_window_steps,
               pm_stage_steps}, {12'h0, dec(am), dec(pm)}, "decode");
      {pa, pp} = {am, pm};
    end
    $display("done: gain load");
    // unused later code above Ah: clamps to Ah and flags in status
    xfer(1'b1, 8'h38, 32'hB5, 3'h2);
    xfer(1'b1, 8'h40, 32'h1, 3'h2);
    xfer(1'b0, 8'h44, 32'h0, 3'h2);
    chk_rd(rd, 32'h04, "status");
    chk_out({12'h0, am_window_steps, am_stage_steps, pm_window_steps, pm_stage_steps},
            {12'h0, dec(4'hA), dec(4'h5)}, "clamp");
    xfer(1'b0, 8'h38, 32'h0, 3'h2);
    chk_rd(rd, 32'hB5, "clamp read");
    $display("done: clamp");
    @(posedge hclk);
    tx_end <= 1'b1;
    @(posedge hclk);
    tx_end <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (squelch_active !== 1'b1 && n < 40);
    chk_out(24'(n), 24'(SQ_CYC), "squelch delay");
    @(posedge hclk);
    mrt_value <= 8'h0F;
    repeat (2) @(posedge hclk);
    #1;
    chk_out({23'h0, squelch_active}, 24'h1, "squelch hold");
    @(posedge hclk);
    mrt_value <= 8'h10;
    @(posedge hclk);
    #1;
    chk_out({23'h0, squelch_active}, 24'h0, "squelch stop");
    @(posedge hclk);
    mrt_value <= 8'h00;
    xfer(1'b1, 8'h30, 32'h0C, 3'h2);
    @(posedge hclk);
    tx_end <= 1'b1;
    @(posedge hclk);
    tx_end <= 1'b0;
    repeat (SQ_CYC + 4) @(posedge hclk);
    #1;
    chk_out({23'h0, squelch_active}, 24'h0, "squelch off");
    $display("done: squelch");
    xfer(1'b1, 8'h30, 32'h28, 3'h2);
    @(posedge hclk);
    rx_active <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk_out({23'h0, agc_active}, 24'h1, "agc start");
    repeat (7) pulse();
    repeat (2) @(posedge hclk);
    #1;
    chk_out({23'h0, agc_active}, 24'h1, "agc seven");
    pulse();
    repeat (2) @(posedge hclk);
    #1;
    chk_out({23'h0, agc_active}, 24'h0, "agc eight");
    xfer(1'b1, 8'h30, 32'h2C, 3'h2);
    repeat (2) @(posedge hclk);
    #1;
    chk_out({23'h0, agc_active}, 24'h1, "agc full");
    xfer(1'b1, 8'h30, 32'h24, 3'h2);
    repeat (2) @(posedge hclk);
    #1;
    chk_out({23'h0, agc_active}, 24'h0, "agc off");
    @(posedge hclk);
    rx_active <= 1'b0;
    $display("done: agc");
    do_reset();
    check_defaults("second reset");
    print_verdict();
  end
endmodule
`default_nettype wire
